// *** core/swallow_divider_pkg.sv ***
// Constants shared by the pulse-swallow feedback divider
package swallow_divider_pkg;
    // Prescaler moduli
    localparam int PRESCALE_LOW  = 100;
    localparam int PRESCALE_HIGH = 101;
    // Phase comparison reference and oscillator offset, in Hz
    localparam int REF_HZ        = 100;
    localparam int OFFSET_HZ     = 35400000;
    // Offset in main divider steps: one step is PRESCALE_LOW times the reference frequency, 10 kHz
    localparam int MAIN_OFFSET   = OFFSET_HZ / (PRESCALE_LOW * REF_HZ);
    // Counter widths
    localparam int DIGIT_W       = 4;
    localparam int MAIN_W        = 14;
    // Main divider terminal value, kept nonzero by design
    localparam logic [13:0] MAIN_TERMINAL = 14'h0001;
    // Fixed portion added to the switch code on each reload
    localparam logic [13:0] MAIN_FIXED    = 14'(MAIN_OFFSET) + MAIN_TERMINAL;
    // Reset values
    localparam logic [3:0]  DIGIT_RESET   = 4'h0;
    // Largest decimal digit of a decade counter
    localparam logic [3:0]  DIGIT_MAX     = 4'h9;
endpackage

// *** core/decade_down_counter.sv ***
// One BCD decade down counter with parallel load and borrow output
`timescale 1ns/1ps
module decade_down_counter (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Control
    input  wire logic       load,
    input  wire logic [3:0] load_value,
    input  wire logic       count_down,
    // State
    output logic [3:0]      count,
    output logic            at_zero
);
    logic [3:0] count_reg;   // Present digit
    logic [3:0] count_next;  // Next digit

    // Load wins over counting; wrap from zero to nine
    always_comb begin
        count_next = count_reg;
        if (load) begin
            count_next = load_value;
        end else if (count_down) begin
            if (count_reg == 4'h0) begin
                count_next = swallow_divider_pkg::DIGIT_MAX;
            end else begin
                count_next = count_reg - 4'h1;
            end
        end
    end

    // Register the digit
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_reg <= swallow_divider_pkg::DIGIT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count   = count_reg;
    assign at_zero = (count_reg == 4'h0);
endmodule

// *** core/dual_modulus_pulse_swallow_divider.sv ***
// Swallow counter and main divider of the synthesizer feedback divider
`timescale 1ns/1ps
module dual_modulus_pulse_swallow_divider #(
    parameter int MAIN_WIDTH = swallow_divider_pkg::MAIN_W
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // Buffered prescaler output, one strobe per prescaler cycle
    input  wire logic                  prescaler_pulse,
    // Frequency switches, BCD except the top digit which runs 0 to 15
    input  wire logic [3:0]            switch_100hz_digit,
    input  wire logic [3:0]            switch_1khz_digit,
    input  wire logic [3:0]            switch_10khz_digit,
    input  wire logic [3:0]            switch_100khz_digit,
    input  wire logic [3:0]            switch_1mhz_digit,
    // Prescaler modulus control, high selects divide by 101
    output logic                       modulus_101,
    // Output pulse toward the phase comparator
    output logic                       divider_out,
    // Observable counter state
    output logic [3:0]                 swallow_low_count,
    output logic [3:0]                 swallow_high_count,
    output logic [MAIN_WIDTH-1:0]      main_count
);
    // Main divider state
    logic [MAIN_WIDTH-1:0] main_cnt_reg;   // Down counter
    logic [MAIN_WIDTH-1:0] main_cnt_next;
    logic                  out_reg;        // Registered reload pulse
    logic                  out_next;
    // Swallow counter state, carry is kept in a flop
    logic                  carry_reg;
    logic                  carry_next;
    // Shared sequencing
    logic                  reload;         // Terminal reached on this pulse
    logic                  swallow_clock;  // Gated clocking of the decades
    logic [MAIN_WIDTH-1:0] load_value;     // Switch code plus fixed portion
    logic [3:0]            low_digit;
    logic [3:0]            high_digit;
    logic                  low_zero;
    logic                  high_zero;
    logic                  swallow_nonzero_after;

    // Switch code of the upper three digits, weighted in decades
    function automatic logic [MAIN_WIDTH-1:0] upper_code(input logic [3:0] d10k,
                                                         input logic [3:0] d100k,
                                                         input logic [3:0] d1m);
        upper_code = MAIN_WIDTH'(d1m) * MAIN_WIDTH'(100) + MAIN_WIDTH'(d100k) * MAIN_WIDTH'(10)
                     + MAIN_WIDTH'(d10k);
    endfunction

    // True when the swallow digit pair holds a nonzero count; shared by the
    // carry decode and the a_zero_load_100 check on it
    function automatic logic digits_nonzero(input logic [3:0] d100,
                                            input logic [3:0] d1k);
        digits_nonzero = (d100 != 4'h0) || (d1k != 4'h0);
    endfunction

    // Reload value: M plus terminal, so the count spans M pulses
    // Switches are read only at a reload, so a change waits for the next frame
    assign load_value = upper_code(switch_10khz_digit, switch_100khz_digit, switch_1mhz_digit)
                        + MAIN_WIDTH'(swallow_divider_pkg::MAIN_FIXED);

    // Reload happens on the pulse that would bring the counter onto the terminal
    // Decoding one above the terminal keeps the span at exactly M pulses, the
    // reload pulse itself being the last of the frame
    assign reload = prescaler_pulse
                    && (main_cnt_reg == MAIN_WIDTH'(swallow_divider_pkg::MAIN_TERMINAL) + MAIN_WIDTH'(1));

    // Carry low blocks clocking; the reload pulse itself only loads
    // Gating the count enable instead of the clock keeps a single clock domain
    assign swallow_clock = prescaler_pulse && carry_reg && !reload;

    // Low decade counts every gated pulse
    decade_down_counter low_decade_swallow_counter (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .load       (reload),
        .load_value (switch_100hz_digit),
        .count_down (swallow_clock),
        .count      (low_digit),
        .at_zero    (low_zero)
    );

    // High decade borrows when the low decade wraps
    decade_down_counter high_decade_swallow_counter (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .load       (reload),
        .load_value (switch_1khz_digit),
        .count_down (swallow_clock && low_zero),
        .count      (high_digit),
        .at_zero    (high_zero)
    );

    // Count left after a decrement is nonzero unless both digits sit at 0/1 boundary
    assign swallow_nonzero_after = !(high_zero && (low_digit == 4'h1));

    // Carry: set by a nonzero load, dropped when the count reaches zero
    // A registered carry keeps the modulus line free of decode glitches
    always_comb begin
        carry_next = carry_reg;
        if (reload) begin
            carry_next = digits_nonzero(switch_100hz_digit, switch_1khz_digit);
        end else if (swallow_clock) begin
            carry_next = swallow_nonzero_after;
        end
    end

    // Main divider: count down on each prescaler pulse, reload instead on the pulse one above the terminal
    // The output pulse is one clock wide, so the comparator must sample every clock
    always_comb begin
        main_cnt_next = main_cnt_reg;
        out_next      = reload;
        if (reload) begin
            main_cnt_next = load_value;
        end else if (prescaler_pulse) begin
            main_cnt_next = main_cnt_reg - MAIN_WIDTH'(1);
        end
    end

    // Register the main divider group; reset arms a reload on the first pulse
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            main_cnt_reg <= MAIN_WIDTH'(swallow_divider_pkg::MAIN_TERMINAL) + MAIN_WIDTH'(1);
            out_reg      <= 1'b0;
        end else begin
            main_cnt_reg <= main_cnt_next;
            out_reg      <= out_next;
        end
    end

    // Register the carry; it starts low so the prescaler divides by 100
    // until the first load has set up a swallow count
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            carry_reg <= 1'b0;
        end else begin
            carry_reg <= carry_next;
        end
    end

    // Modulus follows the carry: high means 101, low means 100
    assign modulus_101        = carry_reg;
    assign divider_out        = out_reg;
    assign swallow_low_count  = low_digit;
    assign swallow_high_count = high_digit;
    assign main_count         = main_cnt_reg;

    // Assertions watch only what this block drives; the switches are taken to
    // hold legal digits, since a non-BCD swallow digit would load as it stands
    // Binary view of the swallow count, for checking only
    logic [6:0] swallow_value;
    assign swallow_value = 7'(high_digit) * 7'd10 + 7'(low_digit);

    a_zero_means_100: assert property (@(posedge clk_sys) disable iff (rst)
        (swallow_value == 7'd0) |-> !modulus_101)
        else $error("modulus 101 selected with swallow count at zero");

    a_load_sets_carry: assert property (@(posedge clk_sys) disable iff (rst)
        reload |=> (modulus_101 == ($past(switch_100hz_digit) != 4'h0 || $past(switch_1khz_digit) != 4'h0)))
        else $error("carry after load does not match loaded value");

    a_load_shows_value: assert property (@(posedge clk_sys) disable iff (rst)
        reload |=> (low_digit == $past(switch_100hz_digit)) && (high_digit == $past(switch_1khz_digit)))
        else $error("loaded digits do not appear on counter outputs");

    a_swallow_decrement: assert property (@(posedge clk_sys) disable iff (rst)
        (prescaler_pulse && modulus_101 && !reload) |=> (swallow_value == $past(swallow_value) - 7'd1))
        else $error("swallow count did not step down by one");

    a_swallow_holds_zero: assert property (@(posedge clk_sys) disable iff (rst)
        (!reload && swallow_value == 7'd0) |=> (swallow_value == 7'd0) && !modulus_101)
        else $error("swallow counter clocked past zero");

    a_main_steps_down: assert property (@(posedge clk_sys) disable iff (rst)
        (prescaler_pulse && !reload) |=> (main_cnt_reg == $past(main_cnt_reg) - MAIN_WIDTH'(1)))
        else $error("main divider missed a prescaler pulse");

    a_main_idle_holds: assert property (@(posedge clk_sys) disable iff (rst)
        !prescaler_pulse |=> $stable(main_cnt_reg))
        else $error("main divider moved without a prescaler pulse");

    a_reload_value: assert property (@(posedge clk_sys) disable iff (rst)
        reload |=> (main_cnt_reg == $past(load_value)) ##0 divider_out)
        else $error("reload value or output pulse wrong");

    a_out_single: assert property (@(posedge clk_sys) disable iff (rst)
        divider_out |-> $past(reload) ##1 !divider_out)
        else $error("output pulse without reload");

    a_terminal_offset: assert property (@(posedge clk_sys) disable iff (rst)
        main_cnt_reg > MAIN_WIDTH'(swallow_divider_pkg::MAIN_TERMINAL))
        else $error("main divider fell to or below its terminal value");

    a_zero_load_100: assert property (@(posedge clk_sys) disable iff (rst)
        (reload && !digits_nonzero(switch_100hz_digit, switch_1khz_digit))
            |=> !modulus_101 && (swallow_value == 7'd0))
        else $error("zero load did not leave modulus 100 selected");

    a_carry_drop_last: assert property (@(posedge clk_sys) disable iff (rst)
        (prescaler_pulse && modulus_101 && !reload && (swallow_value == 7'd1)) |=> !modulus_101)
        else $error("modulus 101 held after the last swallowed pulse");

    a_swallow_idle_holds: assert property (@(posedge clk_sys) disable iff (rst)
        !prescaler_pulse |=> $stable(swallow_value) && $stable(modulus_101))
        else $error("swallow counter moved without a prescaler pulse");

    a_reload_loads_swallow: assert property (@(posedge clk_sys) disable iff (rst)
        divider_out |-> (low_digit == $past(switch_100hz_digit)) && (high_digit == $past(switch_1khz_digit)))
        else $error("swallow load did not coincide with main reload");
endmodule

// *** verification/prescaler_model.sv ***
// Behavioural dual-modulus prescaler that strobes the divider and tallies moduli
`timescale 1ns/1ps
module prescaler_model (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Modulus request and strobe spacing
    input  wire logic        modulus_101,
    input  wire logic [3:0]  gap,
    // Strobe toward the divider and running tallies
    output logic             prescaler_pulse,
    output logic [31:0]      pulse_total,
    output logic [31:0]      high_total
);
    logic [3:0] wait_reg; // Cycles since the last strobe
    // A gap of one gives back-to-back strobes, the harshest spacing allowed
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wait_reg        <= 4'h0;
            prescaler_pulse <= 1'b0;
            pulse_total     <= 32'h0;
            high_total      <= 32'h0;
        end else begin
            wait_reg        <= (wait_reg + 4'h1 >= gap) ? 4'h0 : wait_reg + 4'h1;
            prescaler_pulse <= (wait_reg + 4'h1 >= gap);
            // Each strobe is tallied, and also counted in high_total when modulus_101 is high
            if (prescaler_pulse) begin
                pulse_total <= pulse_total + 32'h1;
                high_total  <= high_total + {31'h0, modulus_101};
            end
        end
    end
endmodule

// *** verification/dual_modulus_pulse_swallow_divider_tb_top.sv ***
// Self-checking bench for the pulse-swallow feedback divider
`timescale 1ns/1ps
module dual_modulus_pulse_swallow_divider_tb_top;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  switch_100hz_digit = 4'h0;
    logic [3:0]  switch_1khz_digit = 4'h0;
    logic [3:0]  switch_10khz_digit = 4'h0;
    logic [3:0]  switch_100khz_digit = 4'h0;
    logic [3:0]  switch_1mhz_digit = 4'h0;
    logic [3:0]  gap = 4'h1;
    logic        prescaler_pulse, modulus_101, divider_out;
    logic [3:0]  swallow_low_count, swallow_high_count;
    logic [13:0] main_count;
    logic [31:0] pulse_total, high_total;
    int          failures = 0;
    int          n_checks = 0;
    dual_modulus_pulse_swallow_divider dut_u (.clk_sys(clk_sys), .rst(rst), .prescaler_pulse(prescaler_pulse),
        .switch_100hz_digit(switch_100hz_digit), .switch_1khz_digit(switch_1khz_digit),
        .switch_10khz_digit(switch_10khz_digit), .switch_100khz_digit(switch_100khz_digit),
        .switch_1mhz_digit(switch_1mhz_digit), .modulus_101(modulus_101), .divider_out(divider_out),
        .swallow_low_count(swallow_low_count), .swallow_high_count(swallow_high_count), .main_count(main_count));
    prescaler_model pre_u (.clk_sys(clk_sys), .rst(rst), .modulus_101(modulus_101), .gap(gap),
        .prescaler_pulse(prescaler_pulse), .pulse_total(pulse_total), .high_total(high_total));
    // 100 MHz clock
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // Count one comparison and report a miss at once
    task automatic chk(input bit ok, input string msg);
        n_checks++;
        if (!ok) begin
            failures++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask
    task automatic final_report();
        $display("Checks %0d, errors %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Sample just after each edge so the edge's updates have landed
    task automatic wait_out();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (divider_out !== 1'b1 && n < 60000);
        chk(divider_out === 1'b1, "no comparator pulse");
    endtask
    // Outputs must sit at their reset values until the first strobe lands
    task automatic reset_check();
        @(posedge clk_sys);
        #1;
        chk(main_count === swallow_divider_pkg::MAIN_TERMINAL + 14'h0001 && modulus_101 === 1'b0
            && divider_out === 1'b0, "reset state");
        chk(swallow_low_count === 4'h0 && swallow_high_count === 4'h0, "reset swallow");
    endtask
    // Load a setting, check the load, then measure one whole frame; the switches are
    // cleared mid-frame to show they only matter at the reload
    task automatic run_frame(input logic [3:0] lo, hi, u, t, h, g);
        int          p, m;
        logic [31:0] pc, hc;
        p = 10 * hi + lo;
        m = 100 * h + 10 * t + u + swallow_divider_pkg::MAIN_OFFSET;
        @(posedge clk_sys);
        {switch_100hz_digit, switch_1khz_digit} <= {lo, hi};
        {switch_10khz_digit, switch_100khz_digit, switch_1mhz_digit} <= {u, t, h};
        gap <= g;
        wait_out();
        wait_out();
        pc = pulse_total;
        hc = high_total;
        chk(swallow_low_count === lo && swallow_high_count === hi, "swallow load");
        chk(modulus_101 === (p != 0), "modulus after load");
        chk(main_count === 14'(m) + swallow_divider_pkg::MAIN_TERMINAL, "main load");
        @(posedge clk_sys);
        {switch_100hz_digit, switch_1khz_digit, switch_1mhz_digit} <= 12'h000;
        {switch_10khz_digit, switch_100khz_digit} <= 8'h00;
        #1;
        chk(divider_out === 1'b0, "pulse longer than a cycle");
        wait_out();
        chk(pulse_total - pc === 32'(m), "frame length");
        chk(high_total - hc === 32'(p), "divide-by-101 count");
        chk(swallow_low_count === 4'h0 && modulus_101 === 1'b0, "zero reload");
    endtask
    // Scenario: swallow count 37 at the 2 MHz setting, a strobe every clock
    task automatic scenario_swallow_37();
        run_frame(4'h7, 4'h3, 4'h0, 4'h0, 4'h2, 4'h1);
    endtask
    // Scenario: zero swallow count, strobes every third clock
    task automatic scenario_zero_swallow();
        run_frame(4'h0, 4'h0, 4'h5, 4'h0, 4'h0, 4'h3);
    endtask
    // Scenario: largest setting, both decades borrow, a strobe every clock
    task automatic scenario_full_scale();
        run_frame(4'h9, 4'h9, 4'h9, 4'h9, 4'hf, 4'h1);
    endtask
    // Hang guard
    initial begin
        #800000;
        failures++;
        $display("Error at %0t: timeout", $time);
        final_report();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        reset_check();
        scenario_swallow_37();
        scenario_zero_swallow();
        scenario_full_scale();
        final_report();
    end
endmodule
